//--- adc_conversion_control.sv
// successive-approximation converter control with an AXI4-Lite register file
// assumes analog comparator, pads and port logic outside, all on aclk
`timescale 1ns/1ps
module adc_conversion_control (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [adc_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [adc_pkg::AXI_AW-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire logic                      alternate_clock,
	input  wire logic                      async_conversion_clock,
	input  wire logic                      hw_trigger_input,
	input  wire logic                      comparator_above,
	output logic                           converter_active,
	output logic                           sample_enable,
	output logic                           async_clock_enable,
	output logic [11:0]                    dac_code,
	output logic [4:0]                     selected_channel,
	output logic                           conversion_irq,
	input  wire logic [7:0]                port_oe_n,
	input  wire logic [7:0]                port_pullup,
	input  wire logic [7:0]                pad_in,
	output logic [7:0]                     pad_oe_n,
	output logic [7:0]                     pad_pullup,
	output logic [7:0]                     pad_input_en,
	output logic [7:0]                     port_read
);
	adc_pkg::core_t r;
	adc_pkg::core_t next_r;

	// bus-side state
	logic                      aw_full, next_aw_full;
	logic                      w_full, next_w_full;
	logic [adc_pkg::AXI_AW-1:0] aw_addr, next_aw_addr;
	logic [7:0]                w_byte, next_w_byte;
	logic                      w_lane, next_w_lane;
	logic                      next_awready, next_wready, next_bvalid;
	logic                      next_arready, next_rvalid;
	logic [1:0]                next_bresp, next_rresp;
	logic [31:0]               next_rdata;
	logic [7:0]                rd_val;
	logic                      rd_hit;

	// decoded controls
	logic       wr_go, wr_en, rd_go, wr_sc1, wr_abort;
	logic       rd_rh, rd_rl, hw_edge, sw_start, hw_start;
	logic [1:0] mode, clk_sel, div_sel;
	logic [2:0] div_max;
	logic [3:0] low_idx;
	logic [4:0] smp_len;
	logic       src_tick, adck_tick, done, xfer, discard, cmp_stop;
	logic       cmp_true;
	logic [11:0] fc, res, cv, val;
	logic [8:0]  sum8;
	logic [10:0] sum10;

	// field decode of configuration and bus strobes
	assign mode     = r.cfg[adc_pkg::CFG_MODE +: 2];
	assign clk_sel  = r.cfg[adc_pkg::CFG_CLK +: 2];
	assign div_sel  = r.cfg[adc_pkg::CFG_DIV +: 2];
	assign div_max  = 3'((4'h1 << div_sel) - 4'h1);
	assign smp_len  = r.cfg[adc_pkg::CFG_LSMP] ? adc_pkg::LONG_SAMPLE - 5'h01
		: adc_pkg::SHORT_SAMPLE - 5'h01;
	// reserved mode code resolves like 8-bit
	assign low_idx  = (mode == adc_pkg::MODE_12 ||
		mode == adc_pkg::MODE_10) ? 4'h0 : 4'h3;
	assign wr_go    = aw_full && w_full && !bvalid;
	assign wr_en    = wr_go && w_lane;
	assign rd_go    = arvalid && arready;
	assign wr_sc1   = wr_en && aw_addr == adc_pkg::OFS_SC1;
	assign wr_abort = wr_en && (aw_addr == adc_pkg::OFS_SC2 ||
		aw_addr == adc_pkg::OFS_CFG || aw_addr == adc_pkg::OFS_CVH ||
		aw_addr == adc_pkg::OFS_CVL);
	assign rd_rh    = rd_go && araddr == adc_pkg::OFS_RH;
	assign rd_rl    = rd_go && araddr == adc_pkg::OFS_RL;
	assign hw_edge  = hw_trigger_input && !r.hw_prev;
	assign sw_start = wr_sc1 && !r.hw_sel &&
		w_byte[adc_pkg::SC1_CH +: 5] != adc_pkg::CH_OFF;
	// busy states and continuous restarts leave no idle slot for an edge
	assign hw_start = r.state == adc_pkg::ST_IDLE && r.hw_sel && hw_edge &&
		r.channel != adc_pkg::CH_OFF && !wr_sc1 && !wr_abort;

	// read data mux; reserved bits read zero
	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (araddr)
			adc_pkg::OFS_SC1: begin
				rd_val[adc_pkg::SC1_FLAG] = r.flag;
				rd_val[adc_pkg::SC1_IRQ] = r.irq_en;
				rd_val[adc_pkg::SC1_CONT] = r.cont_en;
				rd_val[adc_pkg::SC1_CH +: 5] = r.channel;
			end
			adc_pkg::OFS_SC2: begin
				rd_val[adc_pkg::SC2_ACT] = r.active;
				rd_val[adc_pkg::SC2_HWT] = r.hw_sel;
				rd_val[adc_pkg::SC2_CMPE] = r.cmp_en;
				rd_val[adc_pkg::SC2_CMPG] = r.cmp_gt;
			end
			adc_pkg::OFS_CFG: rd_val = r.cfg;
			adc_pkg::OFS_CVH: rd_val = r.cvh;
			adc_pkg::OFS_CVL: rd_val = r.cvl;
			adc_pkg::OFS_RH: rd_val = r.res_h;
			adc_pkg::OFS_RL: rd_val = r.res_l;
			adc_pkg::OFS_PD: rd_val = r.pin_dis;
			default: rd_hit = 1'b0;
		endcase
	end

	// bus handshakes: address and data held until both are in
	always_comb begin
		next_aw_addr = aw_addr;
		next_w_byte  = w_byte;
		next_w_lane  = w_lane;
		next_aw_full = aw_full;
		next_w_full  = w_full;
		next_bvalid  = bvalid && !bready;
		next_bresp   = bresp;
		next_rvalid  = rvalid && !rready;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_full = 1'b1;
			next_w_byte = wdata[7:0];
			next_w_lane = wstrb[0];
		end
		if (wr_go) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (aw_addr[1:0] == 2'h0 && aw_addr <= adc_pkg::OFS_PD)
				? adc_pkg::RESP_OKAY : adc_pkg::RESP_DECERR;
		end
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rdata  = {24'h000000, rd_val};
			next_rresp  = rd_hit ? adc_pkg::RESP_OKAY : adc_pkg::RESP_DECERR;
		end
		next_awready = !next_aw_full;
		next_wready  = !next_w_full;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= '0;
			w_byte  <= 8'h00;
			w_lane  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= adc_pkg::RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= adc_pkg::RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
			aw_addr <= next_aw_addr;
			w_byte  <= next_w_byte;
			w_lane  <= next_w_lane;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// resolved code, rounding and compare of the bit being decided now
	always_comb begin
		fc = r.code;
		if (!comparator_above)
			fc[r.idx] = 1'b0;
		sum8  = {1'b0, fc[11:4]} + 9'(fc[3]);
		sum10 = {1'b0, fc[11:2]} + 11'(fc[1]);
		case (mode)
			adc_pkg::MODE_12: begin
				res = fc;
				cv  = {r.cvh[3:0], r.cvl};
			end
			adc_pkg::MODE_10: begin
				res = {2'h0, sum10[10] ? 10'h3ff : sum10[9:0]};
				cv  = {2'h0, r.cvh[1:0], r.cvl};
			end
			default: begin // reserved code behaves as 8-bit
				res = {4'h0, sum8[8] ? 8'hff : sum8[7:0]};
				cv  = {4'h0, r.cvl};
			end
		endcase
		cmp_true = r.cmp_gt ? (res >= cv) : (res < cv);
		val = r.cmp_en ? 12'(res - cv) : res;
	end

	// registers and conversion sequencer
	always_comb begin
		next_r = r;
		next_r.hw_prev    = hw_trigger_input;
		next_r.alt_prev   = alternate_clock;
		next_r.async_prev = async_conversion_clock;
		next_r.half       = !r.half;
		done = 1'b0;
		xfer = 1'b0;
		discard = 1'b0;
		cmp_stop = 1'b0;
		adck_tick = 1'b0;
		case (clk_sel)
			adc_pkg::CLK_BUS: src_tick = 1'b1;
			adc_pkg::CLK_HALF: src_tick = r.half;
			adc_pkg::CLK_ALT: src_tick = alternate_clock && !r.alt_prev;
			default: src_tick = async_conversion_clock && !r.async_prev;
		endcase
		// divider only counts while sampling or converting
		if (r.state != adc_pkg::ST_IDLE && src_tick) begin
			if (r.div_cnt == div_max) begin
				adck_tick = 1'b1;
				next_r.div_cnt = 3'h0;
			end else
				next_r.div_cnt = r.div_cnt + 3'h1;
		end
		// read side effects
		if (rd_rh && low_idx == 4'h0)
			next_r.block = 1'b1;
		if (rd_rl) begin
			next_r.block = 1'b0;
			next_r.flag  = 1'b0;
		end
		if (wr_en) begin
			case (aw_addr)
				adc_pkg::OFS_SC1: begin
					next_r.channel = w_byte[adc_pkg::SC1_CH +: 5];
					next_r.irq_en  = w_byte[adc_pkg::SC1_IRQ];
					next_r.cont_en = w_byte[adc_pkg::SC1_CONT];
					next_r.flag    = 1'b0;
				end
				adc_pkg::OFS_SC2: begin
					next_r.hw_sel = w_byte[adc_pkg::SC2_HWT];
					next_r.cmp_en = w_byte[adc_pkg::SC2_CMPE];
					next_r.cmp_gt = w_byte[adc_pkg::SC2_CMPG];
				end
				adc_pkg::OFS_CFG: next_r.cfg = w_byte;
				adc_pkg::OFS_CVH: next_r.cvh = w_byte;
				adc_pkg::OFS_CVL: next_r.cvl = w_byte;
				adc_pkg::OFS_PD: next_r.pin_dis = w_byte;
				default: ;
			endcase
		end
		if (wr_sc1 || wr_abort) begin
			next_r.state = adc_pkg::ST_IDLE;
			next_r.block = 1'b0;
		end else begin
			case (r.state)
				adc_pkg::ST_IDLE: begin
					if (hw_start) begin
						next_r.state   = adc_pkg::ST_SAMPLE;
						next_r.smp_cnt = 5'h00;
						next_r.div_cnt = 3'h0;
					end
				end
				adc_pkg::ST_SAMPLE: begin
					if (adck_tick) begin
						if (r.smp_cnt == smp_len) begin
							next_r.state = adc_pkg::ST_CONVERT;
							next_r.code  = 12'h800;
							next_r.idx   = 4'hb;
						end else
							next_r.smp_cnt = r.smp_cnt + 5'h01;
					end
				end
				adc_pkg::ST_CONVERT: begin
					if (adck_tick) begin
						next_r.code = fc;
						if (r.idx == low_idx)
							done = 1'b1;
						else begin
							next_r.code[r.idx - 4'h1] = 1'b1;
							next_r.idx = r.idx - 4'h1;
						end
					end
				end
				default: next_r.state = adc_pkg::ST_IDLE;
			endcase
			if (done) begin
				next_r.state   = adc_pkg::ST_SAMPLE;
				next_r.smp_cnt = 5'h00;
				if (r.cmp_en && !cmp_true) begin
					cmp_stop = 1'b1;
					if (!r.cont_en)
						next_r.state = adc_pkg::ST_IDLE;
				end else if (r.block)
					discard = 1'b1;
				else begin
					xfer = 1'b1;
					next_r.res_l = val[7:0];
					case (mode)
						adc_pkg::MODE_12: next_r.res_h = {4'h0, val[11:8]};
						adc_pkg::MODE_10: next_r.res_h = {6'h00, val[9:8]};
						default: next_r.res_h = 8'h00;
					endcase
					next_r.flag = 1'b1; // set wins over clear
					if (!r.cont_en)
						next_r.state = adc_pkg::ST_IDLE;
				end
			end
		end
		if (sw_start) begin
			next_r.state   = adc_pkg::ST_SAMPLE;
			next_r.smp_cnt = 5'h00;
			next_r.div_cnt = 3'h0;
		end
		// registered status outputs
		next_r.active    = next_r.state != adc_pkg::ST_IDLE;
		next_r.sample_en = next_r.state == adc_pkg::ST_SAMPLE;
		next_r.async_en  = next_r.active &&
			next_r.cfg[adc_pkg::CFG_CLK +: 2] == adc_pkg::CLK_ASYNC;
		next_r.irq       = next_r.flag && next_r.irq_en;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r         <= '0;
			r.channel <= adc_pkg::CH_RESET;
		end else
			r <= next_r;
	end

	assign converter_active   = r.active;
	assign sample_enable      = r.sample_en;
	assign async_clock_enable = r.async_en;
	assign dac_code           = r.code;
	assign selected_channel   = r.channel;
	assign conversion_irq     = r.irq;

	// pad control per channel, registered
	logic [7:0] next_pad_oe_n, next_pad_pullup, next_pad_input_en;
	logic [7:0] next_port_read;
	for (genvar i = 0; i < 8; i++) begin : g_pin
		assign next_pad_oe_n[i]     = r.pin_dis[i] || port_oe_n[i];
		assign next_pad_pullup[i]   = !r.pin_dis[i] && port_pullup[i];
		assign next_pad_input_en[i] = !r.pin_dis[i];
		assign next_port_read[i]    = !r.pin_dis[i] && pad_in[i];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_oe_n     <= 8'hff;
			pad_pullup   <= 8'h00;
			pad_input_en <= 8'h00;
			port_read    <= 8'h00;
		end else begin
			pad_oe_n     <= next_pad_oe_n;
			pad_pullup   <= next_pad_pullup;
			pad_input_en <= next_pad_input_en;
			port_read    <= next_port_read;
		end
	end

	// checks on the sequencer
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_off_channel;
		wr_sc1 && w_byte[4:0] == adc_pkg::CH_OFF |=> !converter_active;
	endproperty
	a_off_channel: assert property (p_off_channel)
		else $error("converter ran with channel all ones");
	property p_idle_after;
		xfer && !r.cont_en |=> !converter_active && !sample_enable;
	endproperty
	a_idle_after: assert property (p_idle_after)
		else $error("single conversion did not go idle");
	property p_flag_irq;
		xfer && r.irq_en |=> r.flag && conversion_irq;
	endproperty
	a_flag_irq: assert property (p_flag_irq)
		else $error("transfer did not raise flag and interrupt");
	property p_hw_start;
		hw_start |=> sample_enable ##0 converter_active;
	endproperty
	a_hw_start: assert property (p_hw_start)
		else $error("hardware edge did not start");
	property p_hw_ignored;
		r.state == adc_pkg::ST_CONVERT && !done && hw_edge &&
		!wr_sc1 && !wr_abort |=> r.state == adc_pkg::ST_CONVERT &&
		!sample_enable;
	endproperty
	a_hw_ignored: assert property (p_hw_ignored)
		else $error("edge disturbed a conversion");
	property p_sw_start;
		sw_start |=> sample_enable [*2];
	endproperty
	a_sw_start: assert property (p_sw_start)
		else $error("software start missed");
	property p_blocked;
		discard |=> $stable(r.res_l) && $stable(r.res_h) && sample_enable;
	endproperty
	a_blocked: assert property (p_blocked)
		else $error("blocked result overwrote or stalled");
	property p_cmp_stop;
		cmp_stop && !r.cont_en |=> !converter_active && $stable(r.res_l);
	endproperty
	a_cmp_stop: assert property (p_cmp_stop)
		else $error("false compare did not stop");
	property p_abort;
		wr_abort |=> !converter_active && $stable(r.res_l) && !r.block;
	endproperty
	a_abort: assert property (p_abort)
		else $error("config write did not abort cleanly");
	property p_eight_bit;
		xfer && mode == adc_pkg::MODE_8 |=> r.res_h == 8'h00;
	endproperty
	a_eight_bit: assert property (p_eight_bit)
		else $error("8-bit result leaked into high register");
	property p_unblock;
		rd_rl && !wr_en |=> !r.block;
	endproperty
	a_unblock: assert property (p_unblock)
		else $error("low read left blocking on");
endmodule : adc_conversion_control

//--- adc_conversion_control_test.sv
// self-checking bench for the converter control block
// assumes the design file, its package and analog_source are compiled first
`timescale 1ns/1ps
module adc_conversion_control_test;
	typedef struct packed {
		logic [7:0]  cfg;
		logic [11:0] lvl;
		logic [7:0]  rh;
		logic [7:0]  rl;
	} row_t;
	// configuration, analog level, expected result bytes
	localparam row_t rows [7] = '{
		'{8'h04, 12'ha5c, 8'h0a, 8'h5c}, '{8'h29, 12'h3ff, 8'h01, 8'h00},
		'{8'h0a, 12'hfff, 8'h03, 8'hff}, '{8'h63, 12'h0f8, 8'h00, 8'h10},
		'{8'h50, 12'hfff, 8'h00, 8'hff}, '{8'h0c, 12'h080, 8'h00, 8'h08},
		'{8'h26, 12'h001, 8'h00, 8'h01}};
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, fire = 1'b0;
	logic [31:0] wdata = 32'h0, rdata, rval;
	logic [3:0]  wstrb = 4'hf;
	logic [1:0]  bresp, rresp, bres, rres;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        alternate_clock = 1'b0, async_conversion_clock = 1'b0;
	logic        hw_trigger_input, comparator_above, converter_active;
	logic        sample_enable, async_clock_enable, conversion_irq;
	logic [11:0] dac_code, level = 12'h000;
	logic [4:0]  selected_channel;
	logic [7:0]  port_oe_n = 8'h00, port_pullup = 8'hff, pad_in = 8'hff;
	logic [7:0]  pad_oe_n, pad_pullup, pad_input_en, port_read;
	logic [2:0]  src_cnt = 3'h0;
	int          errors = 0, n_checks = 0, cycles = 0;

	adc_conversion_control uut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .alternate_clock,
		.async_conversion_clock, .hw_trigger_input, .comparator_above,
		.converter_active, .sample_enable, .async_clock_enable, .dac_code,
		.selected_channel, .conversion_irq, .port_oe_n, .port_pullup, .pad_in,
		.pad_oe_n, .pad_pullup, .pad_input_en, .port_read);
	analog_source far_side (.aclk, .level, .dac_code, .converter_active,
		.fire, .comparator_above, .hw_trigger_input);

	always #2.5 aclk = ~aclk;

	// alternate source ticks every 2 cycles, async source every 8
	always @(posedge aclk) begin
		src_cnt <= src_cnt + 3'h1;
		alternate_clock <= src_cnt[0];
		async_conversion_clock <= src_cnt[2];
	end

	// hang guard; the longest row needs about 840 cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// write: both channels offered together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'b1);
		bres = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rval = rdata;
		rres = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rchk(input logic [4:0] a, input logic [7:0] v,
		input string what);
		rd(a);
		chk(what, {24'h0, v}, rval);
	endtask : rchk

	// polls only the status register while a conversion runs
	task automatic wait_done();
		int k = 0;
		rval = 32'h0;
		while (rval[7] !== 1'b1 && k < 600) begin
			rd(adc_pkg::OFS_SC1);
			k++;
		end
		chk("complete_flag", 32'h1, {31'h0, rval[7]});
	endtask : wait_done

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(adc_pkg::OFS_SC1, 8'h1f, "status_first");
		rchk(adc_pkg::OFS_CFG, 8'h00, "config");
		rchk(adc_pkg::OFS_PD, 8'h00, "pin_disable");
		rd(5'h02);
		chk("unaligned_resp", 32'h3, {30'h0, rres});
		wr(adc_pkg::OFS_RH, 8'h55);
		chk("ro_write_resp", 32'h0, {30'h0, bres});
		rchk(adc_pkg::OFS_RH, 8'h00, "result_high_ro");
		wr(5'h02, 8'h00);
		chk("bad_write_resp", 32'h3, {30'h0, bres});
		chk("idle_reset", 32'h0, {31'h0, converter_active});
		chk("channel_reset", 32'h1f, {27'h0, selected_channel});
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			wr(adc_pkg::OFS_CFG, rows[i].cfg);
			level <= rows[i].lvl;
			wr(adc_pkg::OFS_SC1, 8'h00);
			chk("sample_en", 32'h1, {31'h0, sample_enable});
			chk("async_en", {31'h0, &rows[i].cfg[1:0]},
				{31'h0, async_clock_enable});
			wait_done();
			rchk(adc_pkg::OFS_RH, rows[i].rh, "result_high");
			rchk(adc_pkg::OFS_RL, rows[i].rl, "result_low");
			rchk(adc_pkg::OFS_SC1, 8'h00, "flag_cleared");
			chk("idle", 32'h0, {31'h0, converter_active});
		end
		$display("test modes done");
		wr(adc_pkg::OFS_PD, 8'ha5);
		repeat (3) @(posedge aclk);
		chk("pad_oe_n", 32'ha5, {24'h0, pad_oe_n});
		chk("pad_pullup", 32'h5a, {24'h0, pad_pullup});
		chk("pad_input_en", 32'h5a, {24'h0, pad_input_en});
		chk("port_read", 32'h5a, {24'h0, port_read});
		wr(adc_pkg::OFS_CFG, 8'h04);
		wr(adc_pkg::OFS_SC1, 8'h1f);
		repeat (4) @(posedge aclk);
		chk("off_all_ones", 32'h0, {31'h0, converter_active});
		$display("test pins done");
		level <= 12'h2b7;
		wr(adc_pkg::OFS_SC1, 8'h20);
		wait_done();
		chk("continuous", 32'h1, {31'h0, converter_active});
		rchk(adc_pkg::OFS_RH, 8'h02, "result_high");
		level <= 12'h9c4;
		repeat (60) @(posedge aclk);
		rchk(adc_pkg::OFS_RL, 8'hb7, "blocked_low");
		repeat (40) @(posedge aclk);
		rchk(adc_pkg::OFS_RH, 8'h09, "unblocked_high");
		rchk(adc_pkg::OFS_RL, 8'hc4, "unblocked_low");
		wr(adc_pkg::OFS_CVH, 8'h00);
		repeat (3) @(posedge aclk);
		chk("aborted", 32'h0, {31'h0, converter_active});
		rchk(adc_pkg::OFS_RL, 8'hc4, "kept_low");
		// reading early on purpose: the blocked single keeps restarting
		level <= 12'h5e1;
		wr(adc_pkg::OFS_SC1, 8'h00);
		rchk(adc_pkg::OFS_RH, 8'h09, "early_high");
		repeat (60) @(posedge aclk);
		chk("blocked_restart", 32'h1, {31'h0, converter_active});
		rchk(adc_pkg::OFS_SC1, 8'h00, "no_flag");
		rchk(adc_pkg::OFS_RL, 8'hc4, "old_low");
		wait_done();
		rchk(adc_pkg::OFS_RH, 8'h05, "result_high");
		chk("dac_code", 32'h5e1, {20'h0, dac_code});
		$display("test blocking done");
		wr(adc_pkg::OFS_SC2, 8'h40);
		wr(adc_pkg::OFS_SC1, 8'h00);
		repeat (4) @(posedge aclk);
		chk("hw_no_start", 32'h0, {31'h0, converter_active});
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		for (int k = 0; k < 10 && converter_active !== 1'b1; k++)
			@(posedge aclk);
		chk("hw_start", 32'h1, {31'h0, converter_active});
		repeat (8) @(posedge aclk);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (12) @(posedge aclk);
		chk("edge_ignored", 32'h0, {31'h0, converter_active});
		rchk(adc_pkg::OFS_SC1, 8'h80, "hw_flag");
		wr(adc_pkg::OFS_SC1, 8'h20);
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		wait_done();
		chk("hw_continuous", 32'h1, {31'h0, converter_active});
		$display("test trigger done");
		wr(adc_pkg::OFS_SC2, 8'h30);
		wr(adc_pkg::OFS_CVH, 8'h08);
		wr(adc_pkg::OFS_CVL, 8'h00);
		level <= 12'h400;
		wr(adc_pkg::OFS_SC1, 8'h40);
		repeat (40) @(posedge aclk);
		chk("cmp_false_stop", 32'h0, {31'h0, converter_active});
		rchk(adc_pkg::OFS_SC1, 8'h40, "cmp_no_flag");
		level <= 12'h900;
		wr(adc_pkg::OFS_SC1, 8'h40);
		wait_done();
		chk("irq", 32'h1, {31'h0, conversion_irq});
		rchk(adc_pkg::OFS_RH, 8'h01, "cmp_high");
		rchk(adc_pkg::OFS_RL, 8'h00, "cmp_low");
		chk("irq_clear", 32'h0, {31'h0, conversion_irq});
		$display("test compare done");
		wrap_up();
	end
endmodule : adc_conversion_control_test

//--- adc_pkg.sv
// constants, register map and state types of the converter control block
// assumes a single aclk domain and an AXI4-Lite master with 32-bit data
package adc_pkg;
	// register byte offsets, one aligned word each
	localparam int AXI_AW = 5;
	localparam logic [4:0] OFS_SC1 = 5'h00;
	localparam logic [4:0] OFS_SC2 = 5'h04;
	localparam logic [4:0] OFS_CFG = 5'h08;
	localparam logic [4:0] OFS_CVH = 5'h0c;
	localparam logic [4:0] OFS_CVL = 5'h10;
	localparam logic [4:0] OFS_RH  = 5'h14;
	localparam logic [4:0] OFS_RL  = 5'h18;
	localparam logic [4:0] OFS_PD  = 5'h1c;

	// field positions of status_control_first
	localparam int SC1_FLAG = 7;
	localparam int SC1_IRQ  = 6;
	localparam int SC1_CONT = 5;
	localparam int SC1_CH   = 0;
	// field positions of status_control_second
	localparam int SC2_ACT  = 7;
	localparam int SC2_HWT  = 6;
	localparam int SC2_CMPE = 5;
	localparam int SC2_CMPG = 4;
	// field positions of converter_configuration
	localparam int CFG_DIV  = 5;
	localparam int CFG_LSMP = 4;
	localparam int CFG_MODE = 2;
	localparam int CFG_CLK  = 0;

	// reset values and the channel-off code
	localparam logic [4:0] CH_RESET  = 5'h1f;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [4:0] CH_OFF    = 5'h1f;

	// conversion mode, clock source encodings
	localparam logic [1:0] MODE_8    = 2'h0;
	localparam logic [1:0] MODE_12   = 2'h1;
	localparam logic [1:0] MODE_10   = 2'h2;
	localparam logic [1:0] CLK_BUS   = 2'h0;
	localparam logic [1:0] CLK_HALF  = 2'h1;
	localparam logic [1:0] CLK_ALT   = 2'h2;
	localparam logic [1:0] CLK_ASYNC = 2'h3;

	// sample phase length in converter clock cycles, rounded up
	localparam logic [4:0] SHORT_SAMPLE = 5'h04;
	localparam logic [4:0] LONG_SAMPLE  = 5'h18;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} conv_state_t;

	typedef struct packed {
		logic [4:0]  channel;
		logic        irq_en;
		logic        cont_en;
		logic        flag;
		logic        hw_sel;
		logic        cmp_en;
		logic        cmp_gt;
		logic [7:0]  cfg;
		logic [7:0]  cvh;
		logic [7:0]  cvl;
		logic [7:0]  res_h;
		logic [7:0]  res_l;
		logic [7:0]  pin_dis;
		logic        block;
		conv_state_t state;
		logic [11:0] code;
		logic [3:0]  idx;
		logic [4:0]  smp_cnt;
		logic [2:0]  div_cnt;
		logic        half;
		logic        alt_prev;
		logic        async_prev;
		logic        hw_prev;
		logic        irq;
		logic        active;
		logic        async_en;
		logic        sample_en;
	} core_t;
endpackage : adc_pkg

//--- analog_source.sv
// partner model: analog level on the selected pin and the trigger source
// assumes the bench sets level and pulses fire for one aclk cycle
`timescale 1ns/1ps
module analog_source (
	input  wire logic        aclk,
	input  wire logic [11:0] level,
	input  wire logic [11:0] dac_code,
	input  wire logic        converter_active,
	input  wire logic        fire,
	output logic             comparator_above,
	output logic             hw_trigger_input
);
	logic [2:0] hold = 3'h0;
	logic       junk = 1'b0;

	// comparator only means something while converting; noise otherwise
	always_comb begin
		if (converter_active)
			comparator_above = (level >= dac_code);
		else
			comparator_above = junk;
	end

	always_ff @(posedge aclk) begin
		junk <= ~junk;
	end

	// each request while the line is low gives one rising edge, held four cycles; a request while high only reloads the hold
	always_ff @(posedge aclk) begin
		if (fire)
			hold <= 3'h4;
		else if (hold != 3'h0)
			hold <= hold - 3'h1;
	end
	assign hw_trigger_input = (hold != 3'h0);
endmodule : analog_source
